// File: hdl/gpio_shared_port.sv
// Shared parallel I/O port with change notification, AXI4-Lite slave.
// Assumes pads and notify inputs are asynchronous; peripherals share MCLK.
// Notes on behaviour
// - Per-pin multiplexers give output data and enable to peripheral or port.
// - Port's own digital output never feeds a sharing peripheral's input.
// - Actively driving peripheral disables port driver; pin stays readable.
// - Enabled but idle peripheral lets the port drive the pin.
// - Direction bit one means input; zero drives the pin from the latch.
// - All implemented direction bits come out of reset set, pins as inputs.
// - Latch register reads stored latch; writes update the latch.
// - Pin register reads sampled pins; writes go to the latch.
// - Unimplemented bits read zero in latch, direction and pin registers.
// - Input-only shared pins behave as dedicated port pins.
// - Open-drain bit set makes the output drive low only.
// - Cleared analog config bit selects analog mode; analog is reset state.
// - Pin is analog if either converter's config bit is cleared.
// - Pin register reads zero for analog input pins.
// - Twenty-four change notify inputs can request an interrupt.
// - Change detection still raises the request in Sleep without clock.
// - Enable bits in two registers allow change interrupts per pin.
// - Pull-up enable bits in two registers switch weak pull-ups per pin.
`timescale 1ns/1ps
module gpio_shared_port #(
	parameter int PW = gpio_port_pkg::PORT_W,
	parameter int CW = gpio_port_pkg::CN_W,
	parameter logic [15:0] IMPL_MASK = gpio_port_pkg::IMPL_MASK_DEF,
	parameter logic [15:0] ANALOG_MASK = gpio_port_pkg::ANALOG_MASK_DEF,
	parameter logic [15:0] INPUT_ONLY_MASK = gpio_port_pkg::INPUT_ONLY_MASK_DEF
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// AXI4-Lite write
	input wire logic [5:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read
	input wire logic [5:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// Pads
	input wire logic [15:0] PAD_IN,
	output logic [15:0] PAD_OUT,
	output logic [15:0] PAD_OE,
	output logic [15:0] ANALOG_MODE,
	// Peripherals sharing the pads
	input wire logic [15:0] PERIPH_EN,
	input wire logic [15:0] PERIPH_OE,
	input wire logic [15:0] PERIPH_OUT,
	output logic [15:0] PERIPH_IN,
	// Change notification
	input wire logic [23:0] CN_IN,
	input wire logic SLEEP,
	output logic [23:0] PULLUP_EN,
	output logic CHANGE_IRQ
);
	logic [15:0] pin_direction_reg;
	logic [15:0] output_latch_reg;
	logic [15:0] open_drain_select_reg;
	logic [15:0] analog_cfg_low_reg_one;
	logic [15:0] analog_cfg_low_reg_two;
	logic [15:0] change_irq_enable_reg_a;
	logic [7:0] change_irq_enable_reg_b;
	logic [15:0] pullup_enable_reg_a;
	logic [7:0] pullup_enable_reg_b;
	logic change_flag;
	logic [15:0] pad_meta;
	logic [15:0] pad_sync;
	logic [23:0] cn_meta;
	logic [23:0] cn_sync;
	logic [23:0] cn_captured;
	logic [23:0] cn_enable;
	logic [23:0] cn_mismatch;
	logic [23:0] cn_raw_mismatch;
	logic [15:0] analog_pin;
	logic [15:0] pin_level;
	logic [15:0] port_drive;
	logic [15:0] periph_drive;
	// Bus state
	logic aw_held;
	logic w_held;
	logic [5:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic wr_hit;
	logic [31:0] rd_word;
	logic rd_hit;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return m;
	endfunction

	// Synchronisers: first stage feeds only the second
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			pad_meta <= gpio_port_pkg::PORT_ZERO;
			pad_sync <= gpio_port_pkg::PORT_ZERO;
			cn_meta <= gpio_port_pkg::CN_ZERO;
			cn_sync <= gpio_port_pkg::CN_ZERO;
		end else begin
			pad_meta <= PAD_IN;
			pad_sync <= pad_meta;
			cn_meta <= CN_IN;
			cn_sync <= cn_meta;
		end
	end

	// Write channel: address and data taken in either order
	assign AWREADY = !aw_held && !BVALID;
	assign WREADY = !w_held && !BVALID;
	assign wr_fire = (aw_held || AWVALID) && (w_held || WVALID) && !BVALID;
	wire [5:0] wr_addr = aw_held ? aw_addr : AWADDR;
	wire [31:0] wr_data = w_held ? w_data : WDATA;
	wire [3:0] wr_strb = w_held ? w_strb : WSTRB;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 6'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			BVALID <= 1'b0;
			BRESP <= gpio_port_pkg::RESP_OKAY;
		end else begin
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				BVALID <= 1'b1;
				BRESP <= wr_hit ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_SLVERR;
			end else begin
				if (AWVALID && AWREADY) begin
					aw_held <= 1'b1;
					aw_addr <= AWADDR;
				end
				if (WVALID && WREADY) begin
					w_held <= 1'b1;
					w_data <= WDATA;
					w_strb <= WSTRB;
				end
				if (BVALID && BREADY) begin
					BVALID <= 1'b0;
				end
			end
		end
	end

	always_comb begin
		unique case (wr_addr)
			gpio_port_pkg::OFS_DIRECTION, gpio_port_pkg::OFS_LATCH,
			gpio_port_pkg::OFS_PIN_LEVEL, gpio_port_pkg::OFS_OPEN_DRAIN,
			gpio_port_pkg::OFS_ANALOG_ONE, gpio_port_pkg::OFS_ANALOG_TWO,
			gpio_port_pkg::OFS_CN_EN_A, gpio_port_pkg::OFS_CN_EN_B,
			gpio_port_pkg::OFS_PULLUP_A, gpio_port_pkg::OFS_PULLUP_B,
			gpio_port_pkg::OFS_STATUS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	wire wr_dir = wr_fire && wr_addr == gpio_port_pkg::OFS_DIRECTION;
	wire wr_lat = wr_fire && (wr_addr == gpio_port_pkg::OFS_LATCH ||
		wr_addr == gpio_port_pkg::OFS_PIN_LEVEL);
	wire wr_stat = wr_fire && wr_addr == gpio_port_pkg::OFS_STATUS;
	wire [31:0] dir_new = merge({16'h0000, pin_direction_reg}, wr_data, wr_strb);
	wire [31:0] lat_new = merge({16'h0000, output_latch_reg}, wr_data, wr_strb);

	// Unimplemented bits are held at zero in direction and latch storage
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			pin_direction_reg <= gpio_port_pkg::DIRECTION_RESET & IMPL_MASK;
		end else if (wr_dir) begin
			pin_direction_reg <= dir_new[15:0] & IMPL_MASK;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			output_latch_reg <= gpio_port_pkg::PORT_ZERO;
		end else if (wr_lat) begin
			// Pin register writes land in the latch, never on the pins
			output_latch_reg <= lat_new[15:0] & IMPL_MASK;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			open_drain_select_reg <= gpio_port_pkg::PORT_ZERO;
			analog_cfg_low_reg_one <= ~ANALOG_MASK;
			analog_cfg_low_reg_two <= ~ANALOG_MASK;
			change_irq_enable_reg_a <= gpio_port_pkg::PORT_ZERO;
			change_irq_enable_reg_b <= 8'h00;
			pullup_enable_reg_a <= gpio_port_pkg::PORT_ZERO;
			pullup_enable_reg_b <= 8'h00;
		end else if (wr_fire) begin
			unique case (wr_addr)
				gpio_port_pkg::OFS_OPEN_DRAIN: open_drain_select_reg <=
					16'(merge({16'h0000, open_drain_select_reg}, wr_data, wr_strb));
				gpio_port_pkg::OFS_ANALOG_ONE: analog_cfg_low_reg_one <=
					16'(merge({16'h0000, analog_cfg_low_reg_one}, wr_data, wr_strb));
				gpio_port_pkg::OFS_ANALOG_TWO: analog_cfg_low_reg_two <=
					16'(merge({16'h0000, analog_cfg_low_reg_two}, wr_data, wr_strb));
				gpio_port_pkg::OFS_CN_EN_A: change_irq_enable_reg_a <=
					16'(merge({16'h0000, change_irq_enable_reg_a}, wr_data, wr_strb));
				gpio_port_pkg::OFS_CN_EN_B: change_irq_enable_reg_b <=
					8'(merge({24'h000000, change_irq_enable_reg_b}, wr_data, wr_strb));
				gpio_port_pkg::OFS_PULLUP_A: pullup_enable_reg_a <=
					16'(merge({16'h0000, pullup_enable_reg_a}, wr_data, wr_strb));
				gpio_port_pkg::OFS_PULLUP_B: pullup_enable_reg_b <=
					8'(merge({24'h000000, pullup_enable_reg_b}, wr_data, wr_strb));
				default: ;
			endcase
		end
	end

	// Either converter can claim a pin for analog use
	assign analog_pin = ~(analog_cfg_low_reg_one & analog_cfg_low_reg_two) & ANALOG_MASK;
	assign ANALOG_MODE = analog_pin;
	assign pin_level = pad_sync & ~analog_pin & IMPL_MASK;
	assign PULLUP_EN = {pullup_enable_reg_b, pullup_enable_reg_a};

	genvar gi;
	generate
		for (gi = 0; gi < PW; gi++) begin : g_pin
			pin_out_cell #(
				.IMPLEMENTED(IMPL_MASK[gi]),
				.INPUT_ONLY(INPUT_ONLY_MASK[gi])
			) u_cell (
				.direction(pin_direction_reg[gi]),
				.latch(output_latch_reg[gi]),
				.open_drain(open_drain_select_reg[gi]),
				.analog(analog_pin[gi]),
				.periph_en(PERIPH_EN[gi]),
				.periph_oe(PERIPH_OE[gi]),
				.periph_out(PERIPH_OUT[gi]),
				.periph_in(PERIPH_IN[gi]),
				.pad_level(pad_sync[gi]),
				.pad_out(PAD_OUT[gi]),
				.pad_oe(PAD_OE[gi]),
				.port_drive(port_drive[gi]),
				.periph_drive(periph_drive[gi])
			);
		end
	endgenerate

	// Change notification
	assign cn_enable = {change_irq_enable_reg_b, change_irq_enable_reg_a};
	assign cn_mismatch = (cn_sync ^ cn_captured) & cn_enable;
	// Unclocked path lets a change be seen while the clock is stopped
	assign cn_raw_mismatch = (CN_IN ^ cn_captured) & cn_enable;
	assign CHANGE_IRQ = change_flag || (SLEEP && |cn_raw_mismatch);

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			cn_captured <= gpio_port_pkg::CN_ZERO;
		end else begin
			cn_captured <= cn_sync;
		end
	end

	// A change in the clearing cycle keeps the flag set
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			change_flag <= 1'b0;
		end else if (|cn_mismatch) begin
			change_flag <= 1'b1;
		end else if (wr_stat && wr_strb[0] && wr_data[gpio_port_pkg::STATUS_FLAG_BIT]) begin
			change_flag <= 1'b0;
		end
	end

	// Read channel: answer one cycle after the address is taken
	assign ARREADY = !RVALID;
	always_comb begin
		rd_word = 32'h00000000;
		rd_hit = 1'b1;
		unique case (ARADDR)
			gpio_port_pkg::OFS_DIRECTION: rd_word[15:0] = pin_direction_reg;
			gpio_port_pkg::OFS_LATCH: rd_word[15:0] = output_latch_reg;
			gpio_port_pkg::OFS_PIN_LEVEL: rd_word[15:0] = pin_level;
			gpio_port_pkg::OFS_OPEN_DRAIN: rd_word[15:0] = open_drain_select_reg;
			gpio_port_pkg::OFS_ANALOG_ONE: rd_word[15:0] = analog_cfg_low_reg_one;
			gpio_port_pkg::OFS_ANALOG_TWO: rd_word[15:0] = analog_cfg_low_reg_two;
			gpio_port_pkg::OFS_CN_EN_A: rd_word[15:0] = change_irq_enable_reg_a;
			gpio_port_pkg::OFS_CN_EN_B: rd_word[7:0] = change_irq_enable_reg_b;
			gpio_port_pkg::OFS_PULLUP_A: rd_word[15:0] = pullup_enable_reg_a;
			gpio_port_pkg::OFS_PULLUP_B: rd_word[7:0] = pullup_enable_reg_b;
			gpio_port_pkg::OFS_STATUS: rd_word[gpio_port_pkg::STATUS_FLAG_BIT] = change_flag;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			RVALID <= 1'b0;
			RDATA <= 32'h00000000;
			RRESP <= gpio_port_pkg::RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			RVALID <= 1'b1;
			RDATA <= rd_word;
			RRESP <= rd_hit ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_SLVERR;
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	a_dir_after_reset: assert property ($fell(RST) |-> pin_direction_reg == IMPL_MASK)
		else $error("direction not all inputs after reset");
	a_peripheral_owns: assert property ((port_drive & periph_drive) == 16'h0000)
		else $error("port and peripheral both drive a pin");
	a_input_no_drive: assert property ((pin_direction_reg & ~periph_drive & PAD_OE) == 16'h0000)
		else $error("input pin driven by port");
	a_open_drain_high: assert property ((open_drain_select_reg & PAD_OE & PAD_OUT) == 16'h0000)
		else $error("open drain pin driven high");
	a_analog_reads_zero: assert property ((pin_level & analog_pin) == 16'h0000)
		else $error("analog pin reads nonzero");
	a_unimpl_zero: assert property (((pin_direction_reg | output_latch_reg | pin_level)
		& ~IMPL_MASK) == 16'h0000)
		else $error("unimplemented bit reads nonzero");
	a_change_sets_flag: assert property (|cn_mismatch |=> change_flag ##1 cn_captured ==
		$past(cn_sync))
		else $error("change did not set flag");
	a_pin_write_latch: assert property (wr_fire && wr_addr == gpio_port_pkg::OFS_PIN_LEVEL
		&& wr_strb == 4'hf |=> output_latch_reg == ($past(wr_data[15:0]) & IMPL_MASK))
		else $error("pin register write missed latch");
	a_write_answer: assert property (wr_fire |=> BVALID [*1] ##0 !AWREADY)
		else $error("write answer missing");

	c_flag_set: cover property (!change_flag ##1 change_flag);
	c_flag_cleared: cover property (change_flag ##1 !change_flag);
	c_periph_drive: cover property (|periph_drive);
	c_open_drain_low: cover property (|(open_drain_select_reg & PAD_OE));
endmodule

// File: hdl/gpio_port_pkg.sv
// Constants shared by the shared I/O port and its self-checking bench.
// Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
package gpio_port_pkg;
	localparam int PORT_W = 16;
	localparam int CN_W = 24;
	localparam int CN_A_W = 16;
	localparam int ADDR_W = 6;
	// Register byte offsets
	localparam logic [5:0] OFS_DIRECTION = 6'h00;
	localparam logic [5:0] OFS_LATCH = 6'h04;
	localparam logic [5:0] OFS_PIN_LEVEL = 6'h08;
	localparam logic [5:0] OFS_OPEN_DRAIN = 6'h0c;
	localparam logic [5:0] OFS_ANALOG_ONE = 6'h10;
	localparam logic [5:0] OFS_ANALOG_TWO = 6'h14;
	localparam logic [5:0] OFS_CN_EN_A = 6'h18;
	localparam logic [5:0] OFS_CN_EN_B = 6'h1c;
	localparam logic [5:0] OFS_PULLUP_A = 6'h20;
	localparam logic [5:0] OFS_PULLUP_B = 6'h24;
	localparam logic [5:0] OFS_STATUS = 6'h28;
	// Status field and bus answers
	localparam int STATUS_FLAG_BIT = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Reset values
	localparam logic [15:0] DIRECTION_RESET = 16'hffff;
	localparam logic [15:0] PORT_ZERO = 16'h0000;
	localparam logic [23:0] CN_ZERO = 24'h000000;
	// Device variant defaults
	localparam logic [15:0] IMPL_MASK_DEF = 16'hffff;
	localparam logic [15:0] ANALOG_MASK_DEF = 16'hffff;
	localparam logic [15:0] INPUT_ONLY_MASK_DEF = 16'h0000;
endpackage

// File: hdl/pin_out_cell.sv
// One pin's output ownership, open-drain shaping and peripheral input gating.
// Assumes pad_level is already synchronised; all logic is combinational.
`timescale 1ns/1ps
module pin_out_cell #(
	parameter bit IMPLEMENTED = 1'b1,
	parameter bit INPUT_ONLY = 1'b0
) (
	// Port side
	input wire logic direction,
	input wire logic latch,
	input wire logic open_drain,
	input wire logic analog,
	// Peripheral side
	input wire logic periph_en,
	input wire logic periph_oe,
	input wire logic periph_out,
	output logic periph_in,
	// Pad side
	input wire logic pad_level,
	output logic pad_out,
	output logic pad_oe,
	output logic port_drive,
	output logic periph_drive
);
	logic data;
	logic drive;

	// An input-only function never competes for the driver
	assign periph_drive = IMPLEMENTED && !INPUT_ONLY && periph_en && periph_oe;
	// Enabled but idle peripheral leaves the pin to the port
	assign port_drive = IMPLEMENTED && !periph_drive && !direction;
	assign data = periph_drive ? periph_out : latch;
	assign drive = periph_drive || port_drive;
	// Open drain only pulls low; a high is a release
	assign pad_oe = drive && !(open_drain && data);
	assign pad_out = data && !open_drain;
	// Port's own drive is not looped back into the peripheral
	assign periph_in = IMPLEMENTED && !analog && !port_drive && pad_level;
endmodule

// File: sim/pad_world.sv
// Board side of the shared port: pads with board pull-ups, and change notify lines.
// Assumes the bench drives the external levels; a driving module wins over them.
`timescale 1ns/1ps
module pad_world (
	// Port pads
	input wire logic [15:0] pad_out,
	input wire logic [15:0] pad_oe,
	input wire logic [15:0] ext_val,
	input wire logic [15:0] ext_oe,
	output logic [15:0] pad_in,
	// Notify lines
	input wire logic [23:0] cn_val,
	input wire logic [23:0] cn_oe,
	input wire logic [23:0] pullup_en,
	output logic [23:0] cn_in
);
	logic [23:0] cn_last = 24'h000000;
	// Released pads float high on board resistors, which open-drain outputs rely on
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val) | (~pad_oe & ~ext_oe);
	// An undriven line without pull-up must not keep looking like its old level
	always @(cn_val or cn_oe) cn_last = (cn_oe & cn_val) | (~cn_oe & cn_last);
	assign cn_in = (cn_oe & cn_val) | (~cn_oe & (pullup_en | ~cn_last));
endmodule

// File: sim/tb.sv
// Self-checking bench for the shared I/O port, driven over AXI4-Lite.
// Assumes pad_world stands for the board; offsets come from the design package.
`timescale 1ns/1ps
module tb;
	logic MCLK = 1'h0;
	logic RST = 1'h1;
	logic [5:0] AWADDR = 6'h00;
	logic [5:0] ARADDR = 6'h00;
	logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0;
	logic ARVALID = 1'h0, RREADY = 1'h0, SLEEP = 1'h0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CHANGE_IRQ;
	logic [31:0] WDATA = 32'h0;
	logic [31:0] RDATA;
	logic [3:0] WSTRB = 4'hf;
	logic [1:0] BRESP, RRESP;
	logic [15:0] PAD_IN, PAD_OUT, PAD_OE, ANALOG_MODE, PERIPH_IN;
	logic [15:0] PERIPH_EN = 16'h0, PERIPH_OE = 16'h0, PERIPH_OUT = 16'h0;
	logic [15:0] ext_val = 16'h1234, ext_oe = 16'hffff;
	logic [23:0] CN_IN, PULLUP_EN;
	logic [23:0] cn_val = 24'h0, cn_oe = 24'hffffff;
	logic [33:0] got;
	int err_count = 0, checks_done = 0, cyc = 0;

	always #12.5 MCLK = ~MCLK;

	// Bit 15 absent and bit 14 input-only, so variant masks are exercised
	gpio_shared_port #(.IMPL_MASK(16'h7fff), .ANALOG_MASK(16'h00ff),
		.INPUT_ONLY_MASK(16'h4000)) i_dut (.MCLK(MCLK), .RST(RST),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
		.WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY), .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE),
		.ANALOG_MODE(ANALOG_MODE), .PERIPH_EN(PERIPH_EN), .PERIPH_OE(PERIPH_OE),
		.PERIPH_OUT(PERIPH_OUT), .PERIPH_IN(PERIPH_IN), .CN_IN(CN_IN),
		.SLEEP(SLEEP), .PULLUP_EN(PULLUP_EN), .CHANGE_IRQ(CHANGE_IRQ));

	pad_world i_pads (.pad_out(PAD_OUT), .pad_oe(PAD_OE), .ext_val(ext_val),
		.ext_oe(ext_oe), .pad_in(PAD_IN), .cn_val(cn_val), .cn_oe(cn_oe),
		.pullup_en(PULLUP_EN), .cn_in(CN_IN));

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge MCLK);
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge MCLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'h1;
		WVALID <= 1'h1;
		BREADY <= 1'h1;
		forever begin
			@(posedge MCLK);
			if (AWVALID && AWREADY) AWVALID <= 1'h0;
			if (WVALID && WREADY) WVALID <= 1'h0;
			if (BVALID) begin
				r = BRESP;
				BREADY <= 1'h0;
				break;
			end
		end
	endtask

	task automatic w(input logic [5:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk({32'h0, r}, {32'h0, gpio_port_pkg::RESP_OKAY});
	endtask

	task automatic rd(input logic [5:0] a, output logic [33:0] v);
		@(posedge MCLK);
		ARADDR <= a;
		ARVALID <= 1'h1;
		RREADY <= 1'h1;
		forever begin
			@(posedge MCLK);
			if (ARVALID && ARREADY) ARVALID <= 1'h0;
			if (RVALID) begin
				v = {RRESP, RDATA};
				RREADY <= 1'h0;
				break;
			end
		end
	endtask

	task automatic rc(input logic [5:0] a, input logic [31:0] e);
		rd(a, got);
		chk(got, {gpio_port_pkg::RESP_OKAY, e});
	endtask

	// Generous ceiling: the whole sequence needs well under 1500 cycles
	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_count++;
			close_out;
		end
	end

	initial begin
		logic [1:0] r;
		tick(2);
		RST <= 1'h0;
		rc(gpio_port_pkg::OFS_DIRECTION, 32'h7fff);
		rc(gpio_port_pkg::OFS_LATCH, 32'h0);
		rc(gpio_port_pkg::OFS_ANALOG_ONE, 32'hff00);
		chk({18'h0, ANALOG_MODE}, 34'h00ff);
		rc(gpio_port_pkg::OFS_PIN_LEVEL, 32'h1200);
		$display("test reset done");
		// Analog pins stay inputs throughout, as software must keep them
		w(gpio_port_pkg::OFS_ANALOG_ONE, 32'hffff);
		w(gpio_port_pkg::OFS_ANALOG_TWO, 32'hffff);
		rc(gpio_port_pkg::OFS_PIN_LEVEL, 32'h1234);
		w(gpio_port_pkg::OFS_ANALOG_ONE, 32'hfffb);
		chk({18'h0, ANALOG_MODE}, 34'h0004);
		rc(gpio_port_pkg::OFS_PIN_LEVEL, 32'h1230);
		w(gpio_port_pkg::OFS_ANALOG_ONE, 32'hffff);
		w(gpio_port_pkg::OFS_ANALOG_TWO, 32'hffef);
		chk({18'h0, ANALOG_MODE}, 34'h0010);
		rc(gpio_port_pkg::OFS_PIN_LEVEL, 32'h1224);
		w(gpio_port_pkg::OFS_ANALOG_TWO, 32'hffff);
		$display("test analog done");
		ext_oe <= 16'hff00;
		w(gpio_port_pkg::OFS_LATCH, 32'hffff);
		rc(gpio_port_pkg::OFS_LATCH, 32'h7fff);
		w(gpio_port_pkg::OFS_PIN_LEVEL, 32'h00a5);
		rc(gpio_port_pkg::OFS_LATCH, 32'h00a5);
		// Only the second byte lane is enabled, so the low byte must survive
		WSTRB <= 4'h2;
		w(gpio_port_pkg::OFS_LATCH, 32'h3c3c);
		WSTRB <= 4'hf;
		rc(gpio_port_pkg::OFS_LATCH, 32'h3ca5);
		w(gpio_port_pkg::OFS_DIRECTION, 32'hff00);
		tick(1);
		rc(gpio_port_pkg::OFS_DIRECTION, 32'h7f00);
		chk({2'h0, PAD_OE, PAD_OUT & 16'h00ff}, {18'h00ff, 16'h00a5});
		rc(gpio_port_pkg::OFS_PIN_LEVEL, 32'h12a5);
		w(gpio_port_pkg::OFS_OPEN_DRAIN, 32'h0003);
		chk({2'h0, PAD_OE & 16'h0003, PAD_OUT & 16'h0002}, {18'h0002, 16'h0});
		w(gpio_port_pkg::OFS_OPEN_DRAIN, 32'h0);
		$display("test port done");
		PERIPH_EN <= 16'h4020;
		PERIPH_OE <= 16'h4020;
		PERIPH_OUT <= 16'h4000;
		tick(1);
		chk({2'h0, PAD_OE & 16'h4020, PAD_OUT & 16'h0020}, {18'h0020, 16'h0});
		rc(gpio_port_pkg::OFS_PIN_LEVEL, 32'h1285);
		PERIPH_OE <= 16'h4000;
		tick(3);
		chk({31'h0, PAD_OUT[5], PERIPH_IN[5], PERIPH_IN[12]}, 34'h5);
		$display("test peripheral done");
		w(gpio_port_pkg::OFS_CN_EN_A, 32'hffff);
		w(gpio_port_pkg::OFS_CN_EN_B, 32'h00ff);
		for (int i = 0; i < 24; i++) begin
			cn_val[i] <= ~cn_val[i];
			tick(4);
			chk({33'h0, CHANGE_IRQ}, 34'h1);
			rc(gpio_port_pkg::OFS_STATUS, 32'h1);
			w(gpio_port_pkg::OFS_STATUS, 32'h1);
			chk({33'h0, CHANGE_IRQ}, 34'h0);
		end
		w(gpio_port_pkg::OFS_CN_EN_A, 32'hfffe);
		cn_val[0] <= ~cn_val[0];
		tick(4);
		chk({33'h0, CHANGE_IRQ}, 34'h0);
		// One edge is too early for the clocked flag, so only the sleep path can answer
		SLEEP <= 1'h1;
		cn_val[1] <= ~cn_val[1];
		tick(1);
		chk({33'h0, CHANGE_IRQ}, 34'h1);
		SLEEP <= 1'h0;
		tick(3);
		w(gpio_port_pkg::OFS_STATUS, 32'h1);
		$display("test notify done");
		// Pull-up enables from both registers appear together on PULLUP_EN
		w(gpio_port_pkg::OFS_PULLUP_A, 32'h1234);
		w(gpio_port_pkg::OFS_PULLUP_B, 32'h0056);
		chk({10'h0, PULLUP_EN}, 34'h561234);
		wr(6'h2c, 32'h1, r);
		chk({32'h0, r}, {32'h0, gpio_port_pkg::RESP_SLVERR});
		rd(6'h2c, got);
		chk(got, {gpio_port_pkg::RESP_SLVERR, 32'h0});
		RST <= 1'h1;
		tick(2);
		RST <= 1'h0;
		rc(gpio_port_pkg::OFS_DIRECTION, 32'h7fff);
		rc(gpio_port_pkg::OFS_LATCH, 32'h0);
		$display("test bus and reset done");
		close_out;
	end
endmodule
